// [hw/vrs_pkg.sv]
// Purpose: Shared constants for the voltage reference sequencer.
// Assumes: 125 MHz system clock, 8-bit reference code in 12.5 mV steps.
// Notes: Times are given in their own unit; cycle counts derive from them.
package vrs_pkg;

  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned STEP_CLK_HZ = 500000;
  // Half period of the step clock in system cycles.
  localparam int unsigned STEP_HALF_CYC = CLK_HZ / STEP_CLK_HZ / 2;

  localparam int unsigned CODE_W = 8;
  // One code LSB in microvolts.
  localparam int unsigned LSB_UV = 12500;
  // Serial ramp slope in microvolts per microsecond.
  localparam int unsigned SLOPE_UV_PER_US = 3000;
  // Cycles per LSB at 3 mV/us, rounded down to stay at or above the typical slope.
  localparam int unsigned SER_STEP_CYC = (LSB_UV * (CLK_HZ / 1000000)) / SLOPE_UV_PER_US;

  // Soft-start: T[ms] = V * 2.56, so one LSB takes 12.5 mV * 2.56 ms/V = 32 us.
  localparam int unsigned SS_MS_PER_V_X100 = 256;
  localparam int unsigned SS_STEP_NS = LSB_UV * SS_MS_PER_V_X100 / 100;
  localparam int unsigned SS_STEP_CYC = SS_STEP_NS / (1000000000 / CLK_HZ);

  // Undervoltage arms once the reference reaches 0.5 V.
  localparam int unsigned UV_ARM_MV = 500;
  localparam logic [7:0] UV_ARM_CODE = 8'(UV_ARM_MV * 1000 / LSB_UV);

  // Protection re-enable delay in switching-clock cycles.
  localparam logic [4:0] MASK_HOLD_CYC = 5'h10;
  // Phase shedding re-enable delay in switching-clock cycles.
  localparam logic [7:0] SHED_HOLD_CYC = 8'h40;

  localparam logic [1:0] DROOP_DEFAULT = 2'h0;
  localparam logic [7:0] CODE_RESET = 8'h00;

  typedef enum logic [1:0] {
    VRS_MODE_PARALLEL,
    VRS_MODE_SERIAL,
    VRS_MODE_FIXED
  } vrs_mode_t;

  typedef enum {
    VRS_ST_OFF,
    VRS_ST_SOFT,
    VRS_ST_RUN,
    VRS_ST_FAULT
  } vrs_state_t;

endpackage : vrs_pkg

// [hw/vrs_ramp.sv]
// Purpose: One rail reference that steps one LSB toward a target per step pulse.
// Assumes: Target may change at any time; the ramp simply follows it.
// Notes: Busy is high whenever the reference differs from the target.
`timescale 1ns/1ns
module vrs_ramp
  import vrs_pkg::*;
#(
  parameter int unsigned W = CODE_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic [W-1:0] target,
  input wire logic step,
  output logic [W-1:0] ref_code,
  output logic busy
);

  logic [W-1:0] ref_r;
  logic [W-1:0] ref_nxt;

  always_comb begin
    ref_nxt = ref_r;
    if (clear) begin
      ref_nxt = '0;
    end else if (step && ref_r < target) begin
      ref_nxt = ref_r + 1'b1;
    end else if (step && ref_r > target) begin
      ref_nxt = ref_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_r <= '0;
    end else begin
      ref_r <= ref_nxt;
    end
  end

  assign ref_code = ref_r;
  assign busy = (ref_r != target);

endmodule : vrs_ramp

// [hw/vrs_sequencer.sv]
// Purpose: Live code transitions, soft-start and driver enable order for two rails.
// Assumes: All inputs synchronous to sys_clk; sw_clk_tick marks switching-clock edges.
// Notes: Rail 0 is the core rail, rail 1 the auxiliary rail.
`timescale 1ns/1ns

// Summary of operation
// - Mask OV, UV and feedback-disconnect during transitions, restore 16 cycles after.
// - Parallel code sampled on step-clock rise, confirmed on the following fall.
// - After confirmation, step one LSB every two step-clock cycles to target.
// - Ignore parallel code changes mid-transition; resume at next rising edge.
// - Step clock runs at 500 kHz.
// - Serial command ramps only the addressed rail at about 3 mV per us.
// - New serial command during a ramp replaces the target.
// - Boot codes are latched once at enable; no live transitions on them.
// - Fixed mode: stable serial line change ramps both rails at 3 mV per us.
// - Overcurrent during a transition latches the fault state, stopping regulation.
// - Soft-start raises each enabled rail from zero; serial mode targets boot code.
// - Soft-start begins only above undervoltage lockout with enable released.
// - Power good released when the digital soft-start ramp completes.
// - Undervoltage detection armed once the reference reaches 0.5 V.
// - Overvoltage and feedback-disconnect detection stay enabled during soft-start.
// - Soft-start rate fixed: duration in ms equals target volts times 2.56.
// - PWM high impedance and driver enable low until the first PWM pulse.
// - After the first pulse PWM drives 0 or 1 and driver enable is high.
// - Low-side hold-off affects the loop only; overvoltage can still turn it on.
// - With host bus disabled the core offset comes from the offset pin.
// - Droop gain defaults to one quarter unless the host bus programs it.
// - Phase shedding resets on a live transition and re-enables after a delay.
module vrs_sequencer
  import vrs_pkg::*;
#(
  parameter int unsigned W = CODE_W,
  parameter int unsigned SS_CYC = SS_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable_in,
  input wire logic supply_ok,
  input wire vrs_mode_t mode_sel,
  input wire logic sw_clk_tick,
  input wire logic [W-1:0] parallel_code,
  input wire logic [W-1:0] boot_code_level,
  input wire logic serial_cmd_valid,
  input wire logic [1:0] serial_cmd_rails,
  input wire logic [W-1:0] serial_cmd_code,
  input wire logic serial_code_clock,
  input wire logic serial_code_data,
  input wire logic [W-1:0] fixed_code,
  input wire logic [1:0] ov_raw,
  input wire logic [1:0] uv_raw,
  input wire logic [1:0] pg_raw,
  input wire logic [1:0] fb_disc_raw,
  input wire logic oc_raw,
  input wire logic [1:0] loop_pwm,
  input wire logic host_bus_disable,
  input wire logic [W-1:0] offset_bus,
  input wire logic [W-1:0] offset_program_pin,
  input wire logic droop_cmd_valid,
  input wire logic [1:0] droop_gain_command,
  output logic [W-1:0] core_ref,
  output logic [W-1:0] aux_rail_ref,
  output logic [W-1:0] core_offset,
  output logic [1:0] droop_gain,
  output logic [1:0] phase_pwm_out,
  output logic [1:0] phase_pwm_oe,
  output logic [1:0] driver_enable_out,
  output logic power_good_out,
  output logic fault_out,
  output logic uv_armed,
  output logic prot_masked,
  output logic phase_shedding_en,
  output logic code_step_clock
);

  initial begin
    if (W < 6 || SS_CYC < 1) begin
      $error("vrs_sequencer: unsupported parameter values");
    end
  end

  vrs_state_t st_r, st_nxt;
  logic [7:0] div_r, div_nxt;
  logic sclk_r, sclk_nxt;
  logic [W-1:0] samp_r, samp_nxt;
  logic cand_r, cand_nxt;
  logic pend_r, pend_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [W-1:0] tgt0_r, tgt0_nxt, tgt1_r, tgt1_nxt;
  logic [W-1:0] boot_r, boot_nxt;
  logic en_d_r, en_d_nxt;
  logic [1:0] fx_last_r, fx_last_nxt;
  logic fx_pend_r, fx_pend_nxt;
  logic [$clog2(SER_STEP_CYC+SS_CYC+1)-1:0] tmr_r, tmr_nxt;
  logic [4:0] mask_r, mask_nxt;
  logic [7:0] shed_r, shed_nxt;
  logic [1:0] started_r, started_nxt;
  logic pg_r, pg_nxt, flt_r, flt_nxt, uvarm_r, uvarm_nxt, ovtrip_r, ovtrip_nxt;
  logic [1:0] pwm_r, pwm_nxt, oe_r, oe_nxt, den_r, den_nxt;
  logic [W-1:0] off_r, off_nxt;
  logic [1:0] droop_r, droop_nxt;
  logic [W-1:0] ref0, ref1;
  logic busy0, busy1, step0, step1, clr, rise, fall, moving;

  function automatic logic any_bit(input logic [1:0] v);
    return v[0] | v[1];
  endfunction : any_bit

  vrs_ramp #(.W(W)) u_core (.sys_clk(sys_clk), .reset(reset), .clear(clr),
    .target(tgt0_r), .step(step0), .ref_code(ref0), .busy(busy0));
  vrs_ramp #(.W(W)) u_aux (.sys_clk(sys_clk), .reset(reset), .clear(clr),
    .target(tgt1_r), .step(step1), .ref_code(ref1), .busy(busy1));

  assign moving = (st_r == VRS_ST_RUN) && (busy0 || busy1 || pend_r || fx_pend_r);
  assign rise = (div_r == 8'(STEP_HALF_CYC - 1)) && !sclk_r;
  assign fall = (div_r == 8'(STEP_HALF_CYC - 1)) && sclk_r;

  always_comb begin
    st_nxt = st_r;
    div_nxt = (div_r == 8'(STEP_HALF_CYC - 1)) ? 8'h00 : div_r + 8'h01;
    sclk_nxt = (div_r == 8'(STEP_HALF_CYC - 1)) ? !sclk_r : sclk_r;
    samp_nxt = samp_r;
    cand_nxt = cand_r;
    pend_nxt = pend_r;
    phase_nxt = phase_r;
    tgt0_nxt = tgt0_r;
    tgt1_nxt = tgt1_r;
    boot_nxt = boot_r;
    en_d_nxt = enable_in;
    fx_last_nxt = {serial_code_clock, serial_code_data};
    fx_pend_nxt = fx_pend_r;
    tmr_nxt = tmr_r + 1'b1;
    step0 = 1'b0;
    step1 = 1'b0;
    clr = 1'b0;
    flt_nxt = flt_r;
    ovtrip_nxt = ovtrip_r;
    started_nxt = started_r;
    pg_nxt = pg_r;
    uvarm_nxt = uvarm_r;
    // boot code latched once at enable
    if (enable_in && !en_d_r) begin
      boot_nxt = boot_code_level;
    end
    case (st_r)
      VRS_ST_OFF: begin
        clr = 1'b1;
        tmr_nxt = '0;
        pg_nxt = 1'b0;
        uvarm_nxt = 1'b0;
        started_nxt = 2'b00;
        if (supply_ok && enable_in) begin
          st_nxt = VRS_ST_SOFT;
          tgt0_nxt = (mode_sel == VRS_MODE_SERIAL) ? boot_nxt :
                     (mode_sel == VRS_MODE_FIXED) ? fixed_code : parallel_code;
          tgt1_nxt = (mode_sel == VRS_MODE_PARALLEL) ? '0 : tgt0_nxt;
        end
      end
      VRS_ST_SOFT: begin
        if (tmr_r >= (SS_CYC - 1)) begin
          tmr_nxt = '0;
          step0 = 1'b1;
          step1 = 1'b1;
        end
        if (ref0 >= UV_ARM_CODE) begin
          uvarm_nxt = 1'b1;
        end
        if (!busy0 && !busy1) begin
          st_nxt = VRS_ST_RUN;
          pg_nxt = 1'b1;
          uvarm_nxt = 1'b1;
          cand_nxt = 1'b0;
          pend_nxt = 1'b0;
        end
      end
      VRS_ST_RUN: begin
        case (mode_sel)
          VRS_MODE_PARALLEL: begin
            if (pend_r || busy0) begin
              // one LSB per two step cycles
              if (rise) begin
                pend_nxt = 1'b0;
                phase_nxt = phase_r + 2'd1;
                step0 = !pend_r && phase_r[0];
              end
            end else if (rise) begin
              samp_nxt = parallel_code;
              cand_nxt = (parallel_code != tgt0_r);
            end else if (fall && cand_r) begin
              cand_nxt = 1'b0;
              if (parallel_code == samp_r) begin
                tgt0_nxt = samp_r;
                pend_nxt = 1'b1;
                phase_nxt = 2'd0;
              end
            end
          end
          VRS_MODE_SERIAL: begin
            if (serial_cmd_valid) begin
              if (serial_cmd_rails[0]) tgt0_nxt = serial_cmd_code;
              if (serial_cmd_rails[1]) tgt1_nxt = serial_cmd_code;
            end
          end
          default: begin
            if (fx_last_r != {serial_code_clock, serial_code_data}) begin
              fx_pend_nxt = 1'b1;
            end else if (fx_pend_r) begin
              fx_pend_nxt = 1'b0;
              tgt0_nxt = fixed_code;
              tgt1_nxt = fixed_code;
            end
          end
        endcase
        if (mode_sel != VRS_MODE_PARALLEL) begin
          if (tmr_r >= SER_STEP_CYC - 1) begin
            tmr_nxt = '0;
            step0 = 1'b1;
            step1 = 1'b1;
          end
        end
        if (oc_raw && moving) begin
          st_nxt = VRS_ST_FAULT;
        end
      end
      default: begin
        pg_nxt = 1'b0;
      end
    endcase
    // overvoltage and feedback checks stay live during soft-start; masked while moving or mask_r is nonzero
    if (st_r != VRS_ST_OFF && !prot_masked_c() && (any_bit(ov_raw) || any_bit(fb_disc_raw)
        || (uvarm_r && any_bit(uv_raw)))) begin
      st_nxt = VRS_ST_FAULT;
      ovtrip_nxt = any_bit(ov_raw);
    end
    if (st_nxt == VRS_ST_FAULT) begin
      flt_nxt = 1'b1;
    end
    if (!enable_in) begin
      st_nxt = VRS_ST_OFF;
      flt_nxt = 1'b0;
      ovtrip_nxt = 1'b0;
    end
    started_nxt = started_nxt | ((st_r != VRS_ST_OFF) ? loop_pwm : 2'b00);
  end

  function automatic logic prot_masked_c();
    return moving || (mask_r != 5'h00);
  endfunction : prot_masked_c

  always_comb begin
    mask_nxt = mask_r;
    shed_nxt = shed_r;
    if (moving) begin
      mask_nxt = MASK_HOLD_CYC;
    end else if (sw_clk_tick && mask_r != 5'h00) begin
      mask_nxt = mask_r - 5'h01;
    end
    if (moving) begin
      shed_nxt = SHED_HOLD_CYC;
    end else if (sw_clk_tick && shed_r != 8'h00) begin
      shed_nxt = shed_r - 8'h01;
    end
    for (int i = 0; i < 2; i++) begin
      pwm_nxt[i] = ovtrip_r ? 1'b0 : loop_pwm[i];
      oe_nxt[i] = ovtrip_r || (started_r[i] && st_r != VRS_ST_FAULT);
      den_nxt[i] = ovtrip_r || (started_r[i] && st_r != VRS_ST_FAULT);
    end
    off_nxt = host_bus_disable ? offset_program_pin : offset_bus;
    droop_nxt = droop_r;
    if (host_bus_disable) begin
      droop_nxt = DROOP_DEFAULT;
    end else if (droop_cmd_valid) begin
      droop_nxt = droop_gain_command;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= VRS_ST_OFF;
      div_r <= 8'h00;
      sclk_r <= 1'b0;
      samp_r <= CODE_RESET;
      cand_r <= 1'b0;
      pend_r <= 1'b0;
      phase_r <= 2'd0;
      tgt0_r <= CODE_RESET;
      tgt1_r <= CODE_RESET;
      boot_r <= CODE_RESET;
      en_d_r <= 1'b0;
      fx_last_r <= 2'b00;
      fx_pend_r <= 1'b0;
      tmr_r <= '0;
      mask_r <= 5'h00;
      shed_r <= 8'h00;
      started_r <= 2'b00;
      pg_r <= 1'b0;
      flt_r <= 1'b0;
      uvarm_r <= 1'b0;
      ovtrip_r <= 1'b0;
      pwm_r <= 2'b00;
      oe_r <= 2'b00;
      den_r <= 2'b00;
      off_r <= CODE_RESET;
      droop_r <= DROOP_DEFAULT;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
      samp_r <= samp_nxt;
      cand_r <= cand_nxt;
      pend_r <= pend_nxt;
      phase_r <= phase_nxt;
      tgt0_r <= tgt0_nxt;
      tgt1_r <= tgt1_nxt;
      boot_r <= boot_nxt;
      en_d_r <= en_d_nxt;
      fx_last_r <= fx_last_nxt;
      fx_pend_r <= fx_pend_nxt;
      tmr_r <= tmr_nxt;
      mask_r <= mask_nxt;
      shed_r <= shed_nxt;
      started_r <= started_nxt;
      pg_r <= pg_nxt;
      flt_r <= flt_nxt;
      uvarm_r <= uvarm_nxt;
      ovtrip_r <= ovtrip_nxt;
      pwm_r <= pwm_nxt;
      oe_r <= oe_nxt;
      den_r <= den_nxt;
      off_r <= off_nxt;
      droop_r <= droop_nxt;
    end
  end

  // Reference outputs come from the ramp flip-flops.
  assign core_ref = ref0;
  assign aux_rail_ref = ref1;
  assign core_offset = off_r;
  assign droop_gain = droop_r;
  assign phase_pwm_out = pwm_r;
  assign phase_pwm_oe = oe_r;
  assign driver_enable_out = den_r;
  assign power_good_out = pg_r;
  assign fault_out = flt_r;
  assign uv_armed = uvarm_r;
  assign prot_masked = (mask_r != 5'h00);
  assign phase_shedding_en = (shed_r == 8'h00) && pg_r;
  assign code_step_clock = sclk_r;

  mask_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    moving |=> mask_r == 5'h10) else $error("mask not reloaded");
  lsless_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r == VRS_ST_SOFT && started_r == 2'b00 && !ovtrip_r) |=> oe_r == 2'b00)
    else $error("driver on before first pulse");
  pg_release_a: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r == VRS_ST_SOFT && st_nxt == VRS_ST_RUN && enable_in) |=> pg_r)
    else $error("power good not released");
  oc_latch_a: assert property (@(posedge sys_clk) disable iff (reset)
    (oc_raw && moving && enable_in) |=> st_r == VRS_ST_FAULT ##1 st_r == VRS_ST_FAULT
    || !enable_in) else $error("overcurrent did not latch");
  uv_arm_a: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r == VRS_ST_SOFT && ref0 < UV_ARM_CODE && !uvarm_r) |=> !uvarm_r || ref0 >= 8'h27)
    else $error("undervoltage armed early");
  ov_lowside_a: assert property (@(posedge sys_clk) disable iff (reset)
    ovtrip_r |=> (den_r == 2'b11 && pwm_r == 2'b00)) else $error("ov low side off");
  droop_def_a: assert property (@(posedge sys_clk) disable iff (reset)
    host_bus_disable |=> droop_r == 2'h0) else $error("droop not default");
  offset_pin_a: assert property (@(posedge sys_clk) disable iff (reset)
    host_bus_disable |=> off_r == $past(offset_program_pin)) else $error("offset source");
  step_clk_a: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(sclk_r) |=> sclk_r [*8]) else $error("step clock too fast");

  cov_soft: cover property (@(posedge sys_clk) st_r == VRS_ST_SOFT ##1 st_r == VRS_ST_RUN);
  cov_par: cover property (@(posedge sys_clk) pend_r ##1 !pend_r);
  cov_ser: cover property (@(posedge sys_clk) serial_cmd_valid && busy0);
  cov_flt: cover property (@(posedge sys_clk) $rose(flt_r));

endmodule : vrs_sequencer

// [sim/vrs_cpu_model.sv]
// Purpose: Processor side that hands voltage codes to the sequencer.
// Assumes: Codes change just after a sys_clk edge.
// Notes: Serial lines stand still because fixed-mode frames are not exercised here.
`timescale 1ns/1ns
module vrs_cpu_model
  import vrs_pkg::*;
(
  input wire logic sys_clk,
  output logic [CODE_W-1:0] parallel_code,
  output logic serial_cmd_valid,
  output logic [1:0] serial_cmd_rails,
  output logic [CODE_W-1:0] serial_cmd_code,
  output logic serial_code_clock,
  output logic serial_code_data,
  output logic [CODE_W-1:0] fixed_code
);
  initial begin
    parallel_code = 8'h30;
    serial_cmd_valid = 1'b0;
    serial_cmd_rails = 2'h0;
    serial_cmd_code = 8'h00;
    serial_code_clock = 1'b0;
    serial_code_data = 1'b0;
    fixed_code = 8'h00;
  end

  // One-cycle command; the code is scrambled afterwards so nothing leans on a stale value.
  task automatic send_cmd(input logic [1:0] rails, input logic [CODE_W-1:0] code);
    @(posedge sys_clk);
    #1;
    serial_cmd_valid = 1'b1;
    serial_cmd_rails = rails;
    serial_cmd_code = code;
    @(posedge sys_clk);
    #1;
    serial_cmd_valid = 1'b0;
    serial_cmd_code = ~code;
  endtask : send_cmd

  task automatic set_parallel(input logic [CODE_W-1:0] code);
    @(posedge sys_clk);
    #1;
    parallel_code = code;
  endtask : set_parallel
endmodule : vrs_cpu_model

// [sim/tb_vrs_sequencer.sv]
// Purpose: Self-checking bench for the reference sequencer.
// Assumes: Soft-start step shortened to 4 cycles; switching tick every 10 cycles.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ns
`define CHK(a, e) chk(32'(a), 32'(e))
module tb_vrs_sequencer;
  import vrs_pkg::*;
  localparam int unsigned SS = 4;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic enable_in = 1'b0;
  logic supply_ok = 1'b0;
  vrs_mode_t mode_sel = VRS_MODE_SERIAL;
  logic sw_clk_tick = 1'b0;
  logic [3:0] tick_cnt = 4'h0;
  logic [7:0] boot_code_level = 8'h30;
  logic oc_raw = 1'b0;
  logic [1:0] ov_raw = 2'h0;
  logic [1:0] uv_raw = 2'h0;
  logic [1:0] loop_pwm = 2'h0;
  logic host_bus_disable = 1'b0;
  logic [7:0] offset_bus = 8'h0a;
  logic [7:0] offset_program_pin = 8'h05;
  logic droop_cmd_valid = 1'b0;
  logic [1:0] droop_gain_command = 2'h2;
  logic [7:0] parallel_code, serial_cmd_code, fixed_code, core_ref, aux_rail_ref, core_offset;
  logic serial_cmd_valid, serial_code_clock, serial_code_data;
  logic [1:0] serial_cmd_rails, droop_gain, phase_pwm_out, phase_pwm_oe, driver_enable_out;
  logic power_good_out, fault_out, uv_armed, prot_masked, phase_shedding_en, code_step_clock;
  int errors = 0;
  int comparisons = 0;
  int n;
  int rises;

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tick_cnt <= (tick_cnt == 4'h9) ? 4'h0 : tick_cnt + 4'h1;
    sw_clk_tick <= (tick_cnt == 4'h9);
  end

  vrs_cpu_model cpu (.sys_clk(sys_clk), .parallel_code(parallel_code),
    .serial_cmd_valid(serial_cmd_valid), .serial_cmd_rails(serial_cmd_rails),
    .serial_cmd_code(serial_cmd_code), .serial_code_clock(serial_code_clock),
    .serial_code_data(serial_code_data), .fixed_code(fixed_code));

  vrs_sequencer #(.SS_CYC(SS)) DUT (.sys_clk(sys_clk), .reset(reset), .enable_in(enable_in),
    .supply_ok(supply_ok), .mode_sel(mode_sel), .sw_clk_tick(sw_clk_tick),
    .parallel_code(parallel_code), .boot_code_level(boot_code_level),
    .serial_cmd_valid(serial_cmd_valid), .serial_cmd_rails(serial_cmd_rails),
    .serial_cmd_code(serial_cmd_code), .serial_code_clock(serial_code_clock),
    .serial_code_data(serial_code_data), .fixed_code(fixed_code), .ov_raw(ov_raw),
    .uv_raw(uv_raw), .pg_raw(2'h3), .fb_disc_raw(2'h0), .oc_raw(oc_raw), .loop_pwm(loop_pwm),
    .host_bus_disable(host_bus_disable), .offset_bus(offset_bus),
    .offset_program_pin(offset_program_pin), .droop_cmd_valid(droop_cmd_valid),
    .droop_gain_command(droop_gain_command), .core_ref(core_ref), .aux_rail_ref(aux_rail_ref),
    .core_offset(core_offset), .droop_gain(droop_gain), .phase_pwm_out(phase_pwm_out),
    .phase_pwm_oe(phase_pwm_oe), .driver_enable_out(driver_enable_out),
    .power_good_out(power_good_out), .fault_out(fault_out), .uv_armed(uv_armed),
    .prot_masked(prot_masked), .phase_shedding_en(phase_shedding_en),
    .code_step_clock(code_step_clock));

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    comparisons++;
    if (a !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Waits a bounded time for one rail to reach a code, then compares it.
  task automatic wait_ref(input bit aux, input logic [7:0] e, input int lim);
    n = 0;
    while (((aux ? aux_rail_ref : core_ref) !== e) && n < lim) begin
      cyc(1);
      n++;
    end
    `CHK(aux ? aux_rail_ref : core_ref, e);
  endtask : wait_ref

  task automatic reset_dut();
    cyc(1);
    reset = 1'b1;
    enable_in = 1'b0;
    supply_ok = 1'b0;
    loop_pwm = 2'h0;
    oc_raw = 1'b0;
    ov_raw = 2'h0;
    uv_raw = 2'h0;
    cyc(20);
    reset = 1'b0;
  endtask : reset_dut

  task automatic start_up(input vrs_mode_t m);
    mode_sel = m;
    enable_in = 1'b1;
    cyc(100);
    `CHK(core_ref, 8'h00);
    supply_ok = 1'b1;
    wait_ref(1'b0, 8'h20, 400);
    `CHK(uv_armed, 1'b0);
    n = 32 * SS;
    while (power_good_out !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    `CHK((n >= 48 * SS) && (n <= 48 * SS + 16), 1'b1);
    `CHK(power_good_out, 1'b1);
    `CHK(core_ref, 8'h30);
    `CHK(uv_armed, 1'b1);
  endtask : start_up

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    $display("watchdog expired at %0t", $time);
    results();
  end

  initial begin
    reset_dut();
    `CHK(driver_enable_out, 2'h0);
    `CHK(droop_gain, DROOP_DEFAULT);
    $display("test reset_values done");
    start_up(VRS_MODE_SERIAL);
    `CHK(aux_rail_ref, 8'h30);
    `CHK(phase_pwm_oe, 2'h0);
    loop_pwm = 2'h3;
    cyc(4);
    `CHK(driver_enable_out, 2'h3);
    `CHK(phase_pwm_oe, 2'h3);
    cpu.send_cmd(2'h2, 8'h33);
    cyc(600);
    `CHK(core_ref, 8'h30);
    `CHK(prot_masked, 1'b1);
    cpu.send_cmd(2'h2, 8'h32);
    wait_ref(1'b1, 8'h32, 3000);
    `CHK(prot_masked, 1'b1);
    cyc(120);
    `CHK(prot_masked, 1'b1);
    cyc(300);
    `CHK(prot_masked, 1'b0);
    `CHK(aux_rail_ref, 8'h32);
    cpu.send_cmd(2'h1, 8'h34);
    cyc(10);
    oc_raw = 1'b1;
    cyc(4);
    `CHK(fault_out, 1'b1);
    $display("test serial_mode done");
    reset_dut();
    host_bus_disable = 1'b1;
    start_up(VRS_MODE_PARALLEL);
    droop_cmd_valid = 1'b1;
    cyc(1);
    droop_cmd_valid = 1'b0;
    cyc(4);
    `CHK(core_offset, 8'h05);
    `CHK(droop_gain, DROOP_DEFAULT);
    host_bus_disable = 1'b0;
    droop_cmd_valid = 1'b1;
    cyc(1);
    droop_cmd_valid = 1'b0;
    cyc(4);
    `CHK(core_offset, 8'h0a);
    `CHK(droop_gain, 2'h2);
    cpu.set_parallel(8'h32);
    cyc(700);
    `CHK(core_ref < 8'h32, 1'b1);
    cpu.set_parallel(8'h34);
    wait_ref(1'b0, 8'h32, 2000);
    cyc(200);
    `CHK(core_ref, 8'h32);
    rises = 0;
    for (int i = 0; i < 2500; i++) begin
      n = int'(code_step_clock);
      cyc(1);
      if (n == 0 && code_step_clock === 1'b1) begin
        rises++;
      end
    end
    `CHK(rises, 10);
    wait_ref(1'b0, 8'h34, 4000);
    // The mask must run out first, or the overvoltage is ignored.
    cyc(200);
    ov_raw = 2'h1;
    cyc(4);
    `CHK(fault_out, 1'b1);
    `CHK(driver_enable_out, 2'h3);
    `CHK(phase_pwm_out, 2'h0);
    $display("test parallel_mode done");
    results();
  end
endmodule : tb_vrs_sequencer
